/* File: design/array_mem.sv */
`timescale 1ns/1ns
// Purpose: Nonvolatile byte array with registered read data and fixed taps
// Assumes: Starts fully erased; never reset
// Notes:   Read returns the value before a same-cycle write
module array_mem
    import flash_pkg::*;
#(
    parameter int            AW        = 8,
    parameter logic [AW-1:0] PROT_ADDR = BPR_IDX[AW-1:0],
    parameter logic [AW-1:0] TRIM_ADDR = TRIM_IDX[AW-1:0]
) (
    // Clock
    input wire logic   sys_clk,
    // Storage port
    array_mem_if.mem   m
);
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] protect;
        logic [7:0] trim;
    } mem_state_t;

    logic [7:0] cells [2**AW];
    mem_state_t st_reg;
    mem_state_t st_next;

    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            cells[i] = ERASED_BYTE;
        end
    end

    always_comb begin
        st_next         = st_reg;
        st_next.rdata   = cells[m.raddr];
        st_next.protect = cells[PROT_ADDR];
        st_next.trim    = cells[TRIM_ADDR];
    end

    // No reset here: contents and taps persist through reset
    // Cell writes have their own process, so the power-up fill and this port are the only writers
    always @(posedge sys_clk) begin
        if (m.we) begin
            cells[m.waddr] <= m.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    assign m.rdata   = st_reg.rdata;
    assign m.protect = st_reg.protect;
    assign m.trim    = st_reg.trim;
endmodule

/* File: design/array_mem_if.sv */
`timescale 1ns/1ns
// Purpose: Port bundle between the controller and the array storage
// Assumes: One write port, one registered read port, two fixed-location taps
// Notes:   Taps show the protect and trim bytes one cycle after any change
interface array_mem_if #(parameter int AW = 8);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;
    logic [7:0]    protect;
    logic [7:0]    trim;

    modport ctrl (output we, waddr, wdata, raddr, input rdata, protect, trim);
    modport mem  (input we, waddr, wdata, raddr, output rdata, protect, trim);
endinterface

/* File: design/flash_array_control.sv */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
// Purpose: Program/erase sequencer and AHB-Lite slave for the flash array
// Assumes: Single word transfers; every answer OKAY; zero wait states unless erasing
// Notes:   Register and array byte addresses are four times their index
module flash_array_control
    import flash_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pins
    input  wire logic        monitor_mode,
    input  wire logic        secure_lock,
    // Analog and trim
    output logic             pump_on,
    output logic [7:0]       osc_trim
);
    localparam int AW = ARRAY_AW;

    typedef struct packed {
        ctrl_t            ctrl;
        logic             bpr_read;
        logic             latched;
        logic [AW-1:0]    lat_addr;
        logic             busy;
        logic [AW-1:0]    ecnt;
        logic [AW-1:0]    elast;
        logic             dp_act;
        logic             dp_write;
        logic             dp_array;
        logic [IDX_W-1:0] dp_idx;
        logic [31:0]      rd_word;
        logic             rd_stale;
        logic             byp;
        logic [7:0]       byp_data;
        logic [1:0]       mon_sync;
        logic [1:0]       sec_sync;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;

    array_mem_if #(.AW(AW)) mif ();

    array_mem #(.AW(AW)) u_mem (
        .sys_clk (sys_clk),
        .m       (mif.mem)
    );

    logic             taken;
    logic             done;
    logic [IDX_W-1:0] a_idx;
    logic             a_ok;
    logic [7:0]       rd_byte;
    logic             secured;
    logic             bpr_clear;
    logic             m_we;
    logic [AW-1:0]    m_waddr;
    logic [7:0]       m_wdata;
    logic [AW-1:0]    m_raddr;

    function automatic logic is_protected(input logic [AW-1:0] addr, input logic [7:0] bpr);
        is_protected = (bpr != ERASED_BYTE) && (addr[AW-1:AW-8] >= bpr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus phase decode

    assign hreadyout = ~s_reg.busy & ~s_reg.rd_stale;
    assign hresp     = 1'b0;
    assign taken     = hsel & htrans[1] & hready;
    assign done      = s_reg.dp_act & hreadyout;
    assign a_idx     = haddr[IDX_W+1:2];
    assign a_ok      = (haddr[31:IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
    assign rd_byte   = s_reg.byp ? s_reg.byp_data : mif.rdata;
    assign secured   = s_reg.mon_sync[1] & s_reg.sec_sync[1];
    assign bpr_clear = (mif.protect == ERASED_BYTE);
    assign m_raddr   = taken ? a_idx[AW-1:0] : s_reg.dp_idx[AW-1:0];

    assign mif.we    = m_we;
    assign mif.waddr = m_waddr;
    assign mif.wdata = m_wdata;
    assign mif.raddr = m_raddr;

    always_comb begin
        if (s_reg.dp_array) begin
            hrdata = {24'h000000, secured ? SECURE_BYTE : rd_byte};
        end else begin
            hrdata = s_reg.rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        ctrl_t w;
        ctrl_t nc;
        w        = ctrl_t'(hwdata[3:0]);
        nc       = s_reg.ctrl;
        s_next   = s_reg;
        m_we     = 1'b0;
        m_waddr  = s_reg.dp_idx[AW-1:0];
        m_wdata  = ERASED_BYTE;

        s_next.mon_sync = {s_reg.mon_sync[0], monitor_mode};
        s_next.sec_sync = {s_reg.sec_sync[0], secure_lock};
        // A read parked behind an erase waits one more cycle for fresh array data
        s_next.rd_stale = s_reg.dp_act & ~s_reg.dp_write & s_reg.busy;

        // Erase engine writes one erased byte per cycle
        if (s_reg.busy) begin
            m_we        = 1'b1;
            m_waddr     = s_reg.ecnt;
            m_wdata     = ERASED_BYTE;
            s_next.ecnt = s_reg.ecnt + AW'(1);
            if (s_reg.ecnt == s_reg.elast) begin
                s_next.busy = 1'b0;
            end
        end

        if (done && s_reg.dp_write && s_reg.dp_idx == CTRL_IDX) begin
            nc.mass = w.mass;
            if (!(w.program_select && w.erase)) begin
                nc.program_select = w.program_select;
                nc.erase          = w.erase;
            end
            if (!w.high_voltage_enable) begin
                nc.high_voltage_enable = 1'b0;
            end else if (!s_reg.ctrl.high_voltage_enable && (nc.program_select || nc.erase)
                         && s_reg.bpr_read && s_reg.latched
                         && !is_protected(s_reg.lat_addr, mif.protect)
                         && !(nc.erase && nc.mass && !bpr_clear)) begin
                nc.high_voltage_enable = 1'b1;
                if (nc.erase) begin
                    s_next.busy = 1'b1;
                    if (nc.mass) begin
                        s_next.ecnt  = '0;
                        s_next.elast = '1;
                    end else begin
                        s_next.ecnt  = {s_reg.lat_addr[AW-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
                        s_next.elast = {s_reg.lat_addr[AW-1:PAGE_SHIFT], {PAGE_SHIFT{1'b1}}};
                    end
                end
            end
            s_next.ctrl = nc;
        end

        // Array writes from software over the register bus
        if (done && s_reg.dp_write && s_reg.dp_array) begin
            if (!(s_reg.ctrl.program_select || s_reg.ctrl.erase)) begin
                m_we = 1'b0;
            end else if (!s_reg.ctrl.high_voltage_enable) begin
                if (!s_reg.latched) begin
                    s_next.latched  = 1'b1;
                    s_next.lat_addr = s_reg.dp_idx[AW-1:0];
                end
            end else if (s_reg.ctrl.program_select
                         && s_reg.dp_idx[AW-1:ROW_SHIFT] == s_reg.lat_addr[AW-1:ROW_SHIFT]
                         && !is_protected(s_reg.dp_idx[AW-1:0], mif.protect)) begin
                m_we    = 1'b1;
                m_waddr = s_reg.dp_idx[AW-1:0];
                m_wdata = rd_byte & hwdata[7:0];
            end
        end

        if (done && !s_reg.dp_write && s_reg.dp_idx == BPR_IDX
            && (s_reg.ctrl.program_select || s_reg.ctrl.erase)) begin
            s_next.bpr_read = 1'b1;
        end

        if (!s_next.ctrl.program_select && !s_next.ctrl.erase) begin
            s_next.bpr_read = 1'b0;
            s_next.latched  = 1'b0;
        end

        // Forward a same-cycle write to the pending read
        s_next.byp      = m_we && (m_waddr == m_raddr);
        s_next.byp_data = m_wdata;

        if (taken) begin
            s_next.dp_act   = 1'b1;
            s_next.dp_write = hwrite;
            s_next.dp_idx   = a_ok ? a_idx : '0;
            s_next.dp_array = a_ok && (&a_idx[IDX_W-1:AW]);
            s_next.rd_word  = 32'h00000000;
            if (a_ok && a_idx == CTRL_IDX) begin
                s_next.rd_word = {28'h0000000, s_reg.ctrl};
            end else if (a_ok && a_idx == STAT_IDX) begin
                s_next.rd_word = {28'h0000000, s_reg.busy, s_reg.latched, s_reg.bpr_read, secured};
            end
        end else if (done) begin
            s_next.dp_act   = 1'b0;
            s_next.dp_array = 1'b0;
        end

        // Synchronous reset; array contents are kept
        if (rst) begin
            s_next          = '0;
            s_next.ctrl     = ctrl_t'(CTRL_RESET);
        end
    end

    always_ff @(posedge sys_clk) begin
        s_reg <= s_next;
    end

    // Pump follows the high voltage bit; no external program supply
    assign pump_on  = s_reg.ctrl.high_voltage_enable;
    assign osc_trim = mif.trim;
endmodule

/* File: design/flash_pkg.sv */
// Purpose: Shared constants and types for the flash array control block
// Assumes: 32-bit AHB-Lite register bus, each register index maps to byte address 4*index
package flash_pkg;
    localparam int          IDX_W       = 16;
    localparam int          ARRAY_AW    = 8;
    localparam logic [15:0] CTRL_IDX    = 16'hFE08;
    localparam logic [15:0] STAT_IDX    = 16'hFE0D;
    localparam logic [15:0] BPR_IDX     = 16'hFFBE;
    localparam logic [15:0] TRIM_IDX    = 16'hFFC0;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [7:0]  SECURE_BYTE = 8'h00;
    localparam int          PAGE_BYTES  = 64;
    localparam int          ROW_BYTES   = 32;
    localparam int          PAGE_SHIFT  = $clog2(PAGE_BYTES);
    localparam int          ROW_SHIFT   = $clog2(ROW_BYTES);
    localparam logic [3:0]  CTRL_RESET  = 4'h0;

    // Control register layout, bit 3 down to bit 0
    typedef struct packed {
        logic high_voltage_enable;
        logic mass;
        logic erase;
        logic program_select;
    } ctrl_t;
endpackage

/* File: dv/cpu_bus_model.sv */
`timescale 1ns/1ns
// Purpose: CPU side of the register bus, single word transfers
// Assumes: Called right after a rising edge; hready is the slave's hreadyout
// Notes:   Waits without limit; the bench watchdog ends a hang
module cpu_bus_model (
    // Clock and answer
    input  wire logic        sys_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic wait_ready();
        do @(posedge sys_clk); while (hready !== 1'b1);
    endtask
    // Program and erase are driven as control register and array writes
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

/* File: dv/flash_array_control_bench.sv */
`timescale 1ns/1ns
// Purpose: Register level tests of the flash array control block
// Assumes: Array powers up erased
// Notes:   Array byte o sits at byte address 0x3FC00 + 4*o
module flash_array_control_bench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        monitor_mode = 1'b0;
    logic        secure_lock = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, pump_on;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  osc_trim;
    int          error_cnt = 0;
    int          samples_checked = 0;
    localparam logic [31:0] CTRL = {14'h0, flash_pkg::CTRL_IDX, 2'b00};
    localparam logic [31:0] STAT = {14'h0, flash_pkg::STAT_IDX, 2'b00};
    always #4 sys_clk = ~sys_clk;
    flash_array_control u_flash_array_control (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .monitor_mode(monitor_mode),
        .secure_lock(secure_lock), .pump_on(pump_on), .osc_trim(osc_trim));
    cpu_bus_model u_cpu_bus_model (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    function automatic logic [31:0] arr(input logic [7:0] o);
        return {14'h0, 8'hFF, o, 2'b00};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_cpu_bus_model.xfer(1'b1, a, d, q);
    endtask
    task automatic see(input string n, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_cpu_bus_model.xfer(1'b0, a, 32'h0, q);
        see($sformatf("addr %h", a), e, q);
    endtask
    task automatic prog(input logic [7:0] o, input logic [7:0] o2, input logic [7:0] d);
        logic [31:0] q;
        wr(CTRL, 32'h1);
        u_cpu_bus_model.xfer(1'b0, arr(8'hBE), 32'h0, q);
        wr(arr(o), 32'hFF);
        chk(STAT, 32'h6);
        wr(CTRL, 32'h9);
        wr(arr(o), {24'h0, d});
        see("pump", 32'h1, {31'h0, pump_on});
        wr(arr(o2), {24'h0, d});
        wr(CTRL, 32'h0);
    endtask
    task automatic erase(input logic [7:0] o, input logic m, input logic [31:0] e);
        logic [31:0] q;
        wr(CTRL, {29'h0, m, 2'h2});
        u_cpu_bus_model.xfer(1'b0, arr(8'hBE), 32'h0, q);
        wr(arr(o), 32'hFF);
        wr(CTRL, {29'h1, m, 2'h2});
        chk(CTRL, e);
        wr(CTRL, 32'h0);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        $display("watchdog expired");
        final_report();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(CTRL, 32'h0);
        chk(arr(8'hBE), 32'hFF);
        chk(32'h10, 32'h0);
        see("trim", 32'hFF, {24'h0, osc_trim});
        wr(arr(8'h10), 32'h0);
        chk(arr(8'h10), 32'hFF);
        wr(CTRL, 32'h3);
        chk(CTRL, 32'h0);
        wr(CTRL, 32'h8);
        chk(CTRL, 32'h0);
        wr(CTRL, 32'h9);
        chk(CTRL, 32'h1);
        wr(CTRL, 32'h0);
        $display("test reset and refusals done");
        prog(8'h41, 8'h60, 8'h12);
        chk(arr(8'h41), 32'h12);
        chk(arr(8'h60), 32'hFF);
        prog(8'h80, 8'h80, 8'h34);
        prog(8'h3F, 8'h3F, 8'h00);
        erase(8'h50, 1'b0, 32'hA);
        chk(arr(8'h41), 32'hFF);
        chk(arr(8'h3F), 32'h0);
        chk(arr(8'h80), 32'h34);
        $display("test program and page erase done");
        prog(8'hC0, 8'hC0, 8'h3C);
        see("trim", 32'h3C, {24'h0, osc_trim});
        erase(8'h00, 1'b1, 32'hE);
        chk(arr(8'h80), 32'hFF);
        see("trim", 32'hFF, {24'h0, osc_trim});
        $display("test mass erase done");
        monitor_mode <= 1'b1;
        prog(8'h90, 8'h90, 8'h77);
        chk(arr(8'h90), 32'h77);
        prog(8'hBE, 8'hBE, 8'hC0);
        erase(8'h00, 1'b1, 32'h6);
        chk(arr(8'h90), 32'h77);
        secure_lock <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(arr(8'h90), 32'h0);
        chk(STAT, 32'h1);
        secure_lock <= 1'b0;
        $display("test monitor and security done");
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(arr(8'hBE), 32'hC0);
        chk(CTRL, 32'h0);
        $display("test second reset done");
        final_report();
    end
endmodule

/* File: dv/flash_array_control_checker.sv */
`timescale 1ns/1ns
// Purpose: Port level checks of the flash array control block
// Assumes: hready is tied to hreadyout
// Notes:   Tracks the data phase from the captured address phase
module flash_array_control_checker
    import flash_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        monitor_mode,
    input wire logic        secure_lock,
    input wire logic        pump_on,
    input wire logic [7:0]  osc_trim
);
    localparam logic [31:0] CTRL_A = {14'h0, CTRL_IDX, 2'b00};
    logic        dp_v;
    logic        dp_w;
    logic [31:0] dp_a;
    logic [8:0]  st_cnt;
    logic [2:0]  sec_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dp_v <= 1'b0;
            dp_w <= 1'b0;
            dp_a <= 32'h0;
            st_cnt <= 9'h0;
            sec_cnt <= 3'h0;
        end else begin
            if (hready) begin
                dp_v <= hsel && htrans[1];
                dp_w <= hwrite;
                dp_a <= haddr;
            end
            st_cnt <= hreadyout ? 9'h0 : st_cnt + 9'h1;
            sec_cnt <= !(monitor_mode && secure_lock) ? 3'h0 : sec_cnt + {2'h0, sec_cnt != 3'h7};
        end
    end
    wire rd_dp = dp_v && !dp_w && hreadyout;
    wire hv_hit = dp_v && dp_w && hreadyout && dp_a == CTRL_A && hwdata[3];
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_hv_write;
        $past(hv_hit, 1) || $past(hv_hit, 2);
    endsequence
    sequence s_ctrl_read;
        rd_dp && dp_a == CTRL_A;
    endsequence
    a_pump_cause: assert property ($rose(pump_on) |-> s_hv_write)
        else $error("pump on without a control write");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !pump_on && hreadyout && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_stall_bound: assert property (st_cnt <= 9'h101)
        else $error("erase stall too long");
    a_stall_pump: assert property (!hreadyout |-> pump_on)
        else $error("stall without high voltage");
    a_secure_zero: assert property (rd_dp && sec_cnt >= 3'h5 && dp_a[31:10] == 22'hFF |-> hrdata == 32'h0)
        else $error("secured array read not zero");
    a_byte_wide: assert property (rd_dp |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_select_lock: assert property (s_ctrl_read |-> !(hrdata[1] && hrdata[0]))
        else $error("both selects set");
endmodule
bind flash_array_control flash_array_control_checker u_checker (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .monitor_mode(monitor_mode),
    .secure_lock(secure_lock), .pump_on(pump_on), .osc_trim(osc_trim));
